// ===== hdl/protection_burst_state_control.sv
module protection_burst_state_control
  import psc_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // enable pin comparators
  input  wire logic en_above_pfc,      // pin above pfc threshold
  input  wire logic en_above_ic,       // pin above whole-ic threshold
  // supply and temperature flags
  input  wire logic supplies_rst,      // both supplies below reset levels
  input  wire logic supplies_ready,    // start levels reached
  input  wire logic otp_active,        // over-temperature, with hysteresis
  // mains sense comparators
  input  wire logic mains_below_rst,   // below reset level
  input  wire logic mains_above_hys,   // above reset level plus hysteresis
  // output sense comparators
  input  wire logic output_sense_ovp,  // above overvoltage threshold
  input  wire logic output_sense_fsp,  // below failed-start threshold
  // burst sense comparators
  input  wire logic burst_below,       // below switching level
  input  wire logic burst_above_hys,   // above level plus hysteresis
  // controller status
  input  wire logic pfc_stopped,       // pfc not switching
  input  wire logic boost_in_reg,      // boost at regulation level
  input  wire logic low_side_gate,     // low-side stroke active
  // timer pin comparators
  input  wire logic timer_above_upper, // timer_rc_pin at upper level
  input  wire logic timer_below_lower, // timer_rc_pin below lower level
  // controller enables
  output logic      pfc_enable,
  output logic      pfc_soft_stop,     // pfc soft-stop request
  output logic      pfc_soft_start,    // pfc restart with soft-start
  output logic      hb_enable,
  output logic      hb_soft_start,     // half-bridge soft-start
  output logic      hb_low_side_hold,  // force low side on, high off
  // supply charge enables
  output logic      ic_supply_charge,
  output logic      regulated_supply_charge,
  // timer pin drive
  output logic      timer_slow_charge,
  output logic      timer_fast_charge,
  output logic      timer_discharge,
  // pin drive and status
  output logic      output_sense_pull_low,
  output logic      burst_hys_sink,
  output psc_state_e state
);

  // ---- synchronisers ----
  // flags packed so one two-stage chain serves all; stage one is read only
  // by stage two, keeping metastability out of the decision logic
  logic [N_FLAGS-1:0] raw_w;
  logic [N_FLAGS-1:0] meta_r;          // first stage
  logic [N_FLAGS-1:0] sync_r;          // second stage, the only one used

  assign raw_w = {en_above_pfc, en_above_ic, supplies_rst, otp_active,
                  mains_below_rst, mains_above_hys, output_sense_ovp,
                  output_sense_fsp, burst_below, burst_above_hys,
                  timer_above_upper, timer_below_lower, supplies_ready};

  // two flip-flops per comparator flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= raw_w;
      sync_r <= meta_r;
    end
  end

  // named views of the synchronised flags
  wire s_en_pfc   = sync_r[12];
  wire s_en_ic    = sync_r[11];
  wire s_sup_rst  = sync_r[10];
  wire s_otp      = sync_r[9];
  wire s_mains_lo = sync_r[8];
  wire s_mains_hi = sync_r[7];
  wire s_ovp      = sync_r[6];
  wire s_fsp      = sync_r[5];
  wire s_burst_lo = sync_r[4];
  wire s_burst_hi = sync_r[3];
  wire s_tmr_up   = sync_r[2];
  wire s_tmr_lo   = sync_r[1];
  wire s_ready    = sync_r[0];

  // status from the controllers is internal digital, used directly
  wire hb_stopped_w = low_side_gate;

  // ---- state registers ----
  psc_state_e state_r, state_nxt;
  tmr_mode_e  tmr_r, tmr_nxt;
  logic       mains_dipped_r, mains_dipped_nxt; // mains fell below reset
  logic       burst_armed_r, burst_armed_nxt;   // output reached fsp once
  logic       hb_halted_r, hb_halted_nxt;       // bridge stopped at low side
  // fast-charge cycles: the upper flag may still show the level left by the
  // protection timer until the synchroniser has seen the pin after entry
  logic [1:0] chg_cnt_r, chg_cnt_nxt;
  wire        chg_settled_w = chg_cnt_r == 2'(SYNC_STAGES + 1);

  // ---- decode ----
  // timer expiry: own charge reached upper, or an external drive
  wire tmr_expired_w = (tmr_r == TMR_PROT) && s_tmr_up;
  wire ext_restart_w = (tmr_r == TMR_IDLE) && s_tmr_up;
  wire fsp_timeout_w = tmr_expired_w && s_fsp;
  wire in_run_w      = (state_r == ST_STARTUP) || (state_r == ST_OPER) ||
                       (state_r == ST_BURST_WIND) || (state_r == ST_HB_OFF);
  wire pin_both_low  = !s_en_pfc && !s_en_ic;
  wire pin_hb_low    = s_en_pfc && !s_en_ic;
  // any of the three ways out of the latch
  wire mains_reset_w = mains_dipped_r && s_mains_hi;
  wire sd_clear_w    = s_sup_rst || mains_reset_w || pin_both_low;
  // bridge stopped, and pfc stopped or boost in regulation, before burst stop
  wire burst_quiet_w = (pfc_stopped || boost_in_reg) && hb_stopped_w;

  // ---- next state, priority thermal > shutdown > restart > pin > burst
  always_comb begin
    state_nxt = state_r;
    if (s_otp) begin
      state_nxt = ST_THERMAL;
    end else if (state_r == ST_THERMAL) begin
      state_nxt = ST_STARTUP;
    end else if (state_r == ST_PROT_SD) begin
      if (sd_clear_w) begin
        state_nxt = pin_both_low ? ST_DISABLED : ST_STARTUP;
      end
    end else if (in_run_w && s_ovp) begin
      state_nxt = ST_PROT_SD;
    end else if (state_r == ST_RESTART) begin
      if (tmr_r == TMR_RST_DECAY && s_tmr_lo) begin
        state_nxt = ST_STARTUP;
      end
    end else if (in_run_w && (fsp_timeout_w || ext_restart_w)) begin
      state_nxt = ST_RESTART;
    end else begin
      case (state_r)
        ST_DISABLED: begin
          if (s_en_pfc && s_en_ic) begin
            state_nxt = ST_STARTUP;
          end
        end
        ST_STARTUP: begin
          if (pin_both_low) begin
            state_nxt = ST_DISABLED;
          end else if (pin_hb_low) begin
            state_nxt = ST_HB_OFF;
          end else if (s_ready) begin
            state_nxt = ST_OPER;
          end
        end
        ST_OPER: begin
          if (pin_both_low) begin
            state_nxt = ST_DISABLED;
          end else if (pin_hb_low) begin
            state_nxt = ST_HB_OFF;
          end else if (burst_armed_r && s_burst_lo) begin
            state_nxt = ST_BURST_WIND;
          end
        end
        ST_BURST_WIND: begin
          if (pin_both_low) begin
            state_nxt = ST_DISABLED;
          end else if (burst_quiet_w) begin
            state_nxt = ST_BURST_STOP;
          end
        end
        ST_BURST_STOP: begin
          if (pin_both_low) begin
            state_nxt = ST_DISABLED;
          end else if (s_burst_hi) begin
            state_nxt = ST_OPER;
          end
        end
        ST_HB_OFF: begin
          if (pin_both_low) begin
            state_nxt = ST_DISABLED;
          end else if (s_en_ic) begin
            state_nxt = ST_OPER;
          end
        end
        default: state_nxt = ST_DISABLED;
      endcase
    end
  end

  // ---- timer mode, restart timing only inside the restart state
  always_comb begin
    tmr_nxt = TMR_IDLE;
    if (state_nxt == ST_RESTART) begin
      // fast charge on entry, decay once the upper level is reached
      if (state_r != ST_RESTART) begin
        tmr_nxt = TMR_RST_CHG;
      end else if (tmr_r == TMR_RST_CHG && s_tmr_up && chg_settled_w) begin
        tmr_nxt = TMR_RST_DECAY;
      end else begin
        tmr_nxt = tmr_r;
      end
    end else if (tmr_expired_w) begin
      tmr_nxt = TMR_IDLE;
    end else if (in_run_w && s_fsp) begin
      tmr_nxt = TMR_PROT;
    end else begin
      tmr_nxt = TMR_IDLE;
    end
  end

  // ---- side flags
  always_comb begin
    mains_dipped_nxt = mains_dipped_r;
    if (state_r != ST_PROT_SD || mains_reset_w) begin
      mains_dipped_nxt = 1'b0;
    end else if (s_mains_lo) begin
      mains_dipped_nxt = 1'b1;
    end
    burst_armed_nxt = burst_armed_r;
    if (state_nxt == ST_DISABLED || state_nxt == ST_RESTART ||
        state_nxt == ST_PROT_SD || state_nxt == ST_THERMAL) begin
      burst_armed_nxt = 1'b0;
    end else if (!s_fsp && in_run_w) begin
      burst_armed_nxt = 1'b1;
    end
    // counts up while fast charging, back to zero otherwise
    chg_cnt_nxt = 2'h0;
    if (tmr_r == TMR_RST_CHG) begin
      chg_cnt_nxt = chg_settled_w ? chg_cnt_r : chg_cnt_r + 2'h1;
    end
    // bridge halts at its low-side stroke
    hb_halted_nxt  = hb_halted_r;
    if (state_nxt != ST_DISABLED && state_nxt != ST_HB_OFF) begin
      hb_halted_nxt = 1'b0;
    end else if (hb_stopped_w) begin
      hb_halted_nxt = 1'b1;
    end
  end

  // ---- outputs, all registered
  wire run_pfc_w = (state_nxt == ST_STARTUP && s_ready) ||
                   state_nxt == ST_OPER || state_nxt == ST_HB_OFF ||
                   state_nxt == ST_BURST_WIND;
  // a running bridge finishes its stroke; a stopped one stays stopped
  wire run_hb_w  = state_nxt == ST_OPER || state_nxt == ST_BURST_WIND ||
                   ((state_nxt == ST_DISABLED || state_nxt == ST_HB_OFF) &&
                    !hb_halted_nxt && hb_enable);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r                 <= ST_DISABLED;
      tmr_r                   <= TMR_IDLE;
      mains_dipped_r          <= RST_LEVEL;
      burst_armed_r           <= RST_LEVEL;
      chg_cnt_r               <= {2{RST_LEVEL}};
      hb_halted_r             <= RST_LEVEL;
      pfc_enable              <= RST_LEVEL;
      pfc_soft_stop           <= RST_LEVEL;
      pfc_soft_start          <= RST_LEVEL;
      hb_enable               <= RST_LEVEL;
      hb_soft_start           <= RST_LEVEL;
      hb_low_side_hold        <= RST_LEVEL;
      ic_supply_charge        <= RST_LEVEL;
      regulated_supply_charge <= RST_LEVEL;
      timer_slow_charge       <= RST_LEVEL;
      timer_fast_charge       <= RST_LEVEL;
      timer_discharge         <= RST_LEVEL;
      output_sense_pull_low   <= RST_LEVEL;
      burst_hys_sink          <= RST_LEVEL;
      state                   <= ST_DISABLED;
    end else begin
      state_r        <= state_nxt;
      tmr_r          <= tmr_nxt;
      mains_dipped_r <= mains_dipped_nxt;
      burst_armed_r  <= burst_armed_nxt;
      chg_cnt_r      <= chg_cnt_nxt;
      hb_halted_r    <= hb_halted_nxt;
      state          <= state_nxt;
      pfc_enable     <= run_pfc_w;
      // soft-stop in burst entry once boost is at regulation
      pfc_soft_stop  <= (state_nxt == ST_BURST_WIND) && boost_in_reg;
      pfc_soft_start <= (state_nxt == ST_OPER) &&
                        (state_r == ST_BURST_STOP);
      hb_enable      <= run_hb_w;
      // half-bridge skips soft-start when leaving burst stop
      hb_soft_start  <= (state_nxt == ST_OPER) &&
                        (state_r == ST_STARTUP);
      hb_low_side_hold <= (state_nxt == ST_DISABLED ||
                           state_nxt == ST_HB_OFF) && hb_halted_nxt;
      ic_supply_charge <= state_nxt == ST_RESTART ||
                          state_nxt == ST_STARTUP;
      regulated_supply_charge <= state_nxt == ST_BURST_STOP ||
                                 (state_nxt == ST_STARTUP && s_ready) ||
                                 run_pfc_w;
      timer_slow_charge <= tmr_nxt == TMR_PROT;
      timer_fast_charge <= tmr_nxt == TMR_RST_CHG;
      // active discharge after expiry or after restart timing ends
      timer_discharge   <= tmr_expired_w ||
                           (state_r == ST_RESTART &&
                            state_nxt != ST_RESTART);
      output_sense_pull_low <= state_nxt == ST_BURST_STOP;
      burst_hys_sink    <= s_burst_lo;
    end
  end

  // ---- assertions
  a_shutdown_latch: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_PROT_SD && !s_otp && !sd_clear_w |=>
    state_r == ST_PROT_SD) else $error("shutdown left without reset");
  a_ovp_to_sd: assert property (@(posedge clk_sys) disable iff (rst)
    in_run_w && s_ovp && !s_otp |=> state_r == ST_PROT_SD)
    else $error("overvoltage missed");
  a_thermal_off: assert property (@(posedge clk_sys) disable iff (rst)
    s_otp |=> state_r == ST_THERMAL ##1 !pfc_enable && !hb_enable)
    else $error("thermal hold not off");
  a_restart_off: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_RESTART |-> !pfc_enable && !hb_enable &&
    !regulated_supply_charge) else $error("restart not off");
  a_fsp_restart: assert property (@(posedge clk_sys) disable iff (rst)
    in_run_w && fsp_timeout_w && !s_otp && !s_ovp |=>
    state_r == ST_RESTART) else $error("failed start missed");
  a_restart_timer: assert property (@(posedge clk_sys) disable iff (rst)
    timer_fast_charge |-> state_r == ST_RESTART)
    else $error("fast charge outside restart");
  a_hys_sink: assert property (@(posedge clk_sys) disable iff (rst)
    burst_hys_sink == $past(s_burst_lo) || $past(rst))
    else $error("hysteresis sink wrong");
  a_burst_pull: assert property (@(posedge clk_sys) disable iff (rst)
    output_sense_pull_low |-> state_r == ST_BURST_STOP && !pfc_enable)
    else $error("pull low outside burst stop");
  a_burst_armed: assert property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_OPER && !burst_armed_r |=> state_r != ST_BURST_WIND)
    else $error("burst before fsp reached");

  c_burst_cycle: cover property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_BURST_STOP ##[1:50] state_r == ST_OPER);
  c_restart_end: cover property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_RESTART ##1 state_r == ST_STARTUP);
  c_sd_mains: cover property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_PROT_SD && mains_reset_w);
  c_hb_off: cover property (@(posedge clk_sys) disable iff (rst)
    state_r == ST_HB_OFF && hb_low_side_hold);

endmodule

// ===== hdl/psc_pkg.sv
package psc_pkg;
  // state codes of the control sequencer
  typedef enum logic [3:0] {
    ST_DISABLED,     // enable pin low, whole ic off
    ST_STARTUP,      // normal start-up: supply charge, boost charge
    ST_OPER,         // operational supply
    ST_BURST_WIND,   // burst entry: waiting for bridge stop, and pfc stop or boost regulation
    ST_BURST_STOP,   // power-saving burst-off period
    ST_HB_OFF,       // only the half-bridge disabled by the enable pin
    ST_RESTART,      // restart timing
    ST_PROT_SD,      // latched protection shutdown
    ST_THERMAL       // thermal hold
  } psc_state_e;

  // timer pin activity
  typedef enum logic [1:0] {
    TMR_IDLE,        // no error, capacitor bleeds through resistor
    TMR_PROT,        // protection timing: slow charge
    TMR_RST_CHG,     // restart timing: fast charge to upper level
    TMR_RST_DECAY    // restart timing: pin high impedance, decay
  } tmr_mode_e;

  // synchroniser depth
  localparam int SYNC_STAGES = 2;
  // number of comparator flags synchronised
  localparam int N_FLAGS = 13;
  // value of every state flip-flop after reset
  localparam logic RST_LEVEL = 1'b0;
endpackage

// ===== verif/psc_far_side.sv
// behavioural far side: timer rc network and power stage status
module psc_far_side (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // timer pin drive from the block
  input  wire logic timer_slow_charge,
  input  wire logic timer_fast_charge,
  input  wire logic timer_discharge,
  input  wire logic timer_force,       // external circuit lifts the pin
  // controller enables from the block
  input  wire logic pfc_enable,
  input  wire logic hb_enable,
  // comparator and status answers
  output logic      timer_above_upper,
  output logic      timer_below_lower,
  output logic      pfc_stopped,
  output logic      low_side_gate
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] level_r;   // capacitor voltage in coarse steps
  logic [1:0] pre_r;     // slow rc prescaler, keeps timing well above latency

  // rc network: fast charge, slow charge, bleed through resistor
  always_ff @(posedge clk_sys) begin
    pre_r <= rst ? 2'h0 : pre_r + 2'h1;
    if (rst || timer_discharge) begin
      level_r <= 4'h0;
    end else if (timer_fast_charge) begin
      level_r <= (level_r > 4'hB) ? 4'hF : level_r + 4'h4;
    end else if (timer_slow_charge && pre_r == 2'h0) begin
      level_r <= (level_r == 4'hF) ? 4'hF : level_r + 4'h1;
    end else if (!timer_slow_charge && pre_r == 2'h0 && level_r != 4'h0) begin
      level_r <= level_r - 4'h1;
    end
  end

  // comparators; the external drive wins over the capacitor level
  assign timer_above_upper = (level_r >= 4'hC) || timer_force;
  assign timer_below_lower = (level_r < 4'h2) && !timer_force;
  // a stopped pfc follows its enable one cycle late
  always_ff @(posedge clk_sys) begin
    pfc_stopped <= !pfc_enable;
  end
  // low side strokes while running, held on when the bridge is stopped
  assign low_side_gate = hb_enable ? pre_r[1] : 1'b1;
endmodule

// ===== verif/protection_burst_state_control_tb_top.sv
module protection_burst_state_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic en_above_pfc = 1'b0, en_above_ic = 1'b0, supplies_rst = 1'b0;
  logic supplies_ready = 1'b0, otp_active = 1'b0, mains_below_rst = 1'b0;
  logic mains_above_hys = 1'b1, output_sense_ovp = 1'b0;
  logic output_sense_fsp = 1'b1;  // output starts below failed-start level
  logic burst_below = 1'b0, burst_above_hys = 1'b1, boost_in_reg = 1'b1;
  logic timer_force = 1'b0;
  logic pfc_stopped, low_side_gate, timer_above_upper, timer_below_lower;
  logic pfc_enable, pfc_soft_stop, pfc_soft_start, hb_enable, hb_soft_start;
  logic hb_low_side_hold, ic_supply_charge, regulated_supply_charge;
  logic timer_slow_charge, timer_fast_charge, timer_discharge;
  logic output_sense_pull_low, burst_hys_sink;
  psc_state_e state;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;

  always #20 clk_sys = ~clk_sys;

  protection_burst_state_control u_protection_burst_state_control (
    .clk_sys, .rst, .en_above_pfc, .en_above_ic, .supplies_rst,
    .supplies_ready, .otp_active, .mains_below_rst, .mains_above_hys,
    .output_sense_ovp, .output_sense_fsp, .burst_below, .burst_above_hys,
    .pfc_stopped, .boost_in_reg, .low_side_gate, .timer_above_upper,
    .timer_below_lower, .pfc_enable, .pfc_soft_stop, .pfc_soft_start,
    .hb_enable, .hb_soft_start, .hb_low_side_hold, .ic_supply_charge,
    .regulated_supply_charge, .timer_slow_charge, .timer_fast_charge,
    .timer_discharge, .output_sense_pull_low, .burst_hys_sink, .state);

  psc_far_side u_psc_far_side (
    .clk_sys, .rst, .timer_slow_charge, .timer_fast_charge,
    .timer_discharge, .timer_force, .pfc_enable, .hb_enable,
    .timer_above_upper, .timer_below_lower, .pfc_stopped, .low_side_gate);

  // verdict and end of run, reached from the sequence or the watchdog
  task automatic finish_test();
    $display("compares %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one compare; four-state case equality so an unknown matches only an unknown
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // bounded wait for a state, then compare it
  task automatic wait_st(input psc_state_e s);
    int n;
    n = 0;
    while (state !== s && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    check("state", state, s);
  endtask

  // enables, low-side hold, supply charges and output sense pull-low as one packed word
  function automatic logic [7:0] outs();
    return {2'h0, pfc_enable, hb_enable, hb_low_side_hold,
            ic_supply_charge, regulated_supply_charge,
            output_sense_pull_low};
  endfunction

  // watchdog well above the length of the sequence
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end

  initial begin
    cyc(10);
    rst = 1'b0;
    check("state", state, ST_DISABLED);
    check("outs", outs(), 8'h00);
    en_above_pfc = 1'b1;
    en_above_ic = 1'b1;
    supplies_ready = 1'b1;
    wait_st(ST_OPER);
    check("hb_ss", hb_soft_start, 8'h01);
    check("enables", {pfc_enable, hb_enable}, 8'h03);
    // burst request before the output ever left the failed-start level
    burst_below = 1'b1;
    burst_above_hys = 1'b0;
    cyc(6);
    check("state", state, ST_OPER);
    check("sink", burst_hys_sink, 8'h01);
    check("slow", timer_slow_charge, 8'h01);
    wait_st(ST_RESTART);
    check("outs", outs(), 8'h04);
    check("fast", timer_fast_charge, 8'h01);
    output_sense_fsp = 1'b0;
    wait_st(ST_STARTUP);
    check("discharge", timer_discharge, 8'h01);
    check("timer", {timer_slow_charge, timer_fast_charge}, 8'h00);
    // burst now allowed: winds down to burst stop
    wait_st(ST_BURST_STOP);
    check("outs", outs(), 8'h03);
    burst_below = 1'b0;
    burst_above_hys = 1'b1;
    wait_st(ST_OPER);
    check("pfc_ss", pfc_soft_start, 8'h01);
    check("hb_ss", hb_soft_start, 8'h00);
    cyc(2);
    check("sink", burst_hys_sink, 8'h00);
    check("enables", {pfc_enable, hb_enable}, 8'h03);
    // short failed-start dip: timer charges then bleeds, no action
    output_sense_fsp = 1'b1;
    cyc(8);
    output_sense_fsp = 1'b0;
    cyc(60);
    check("state", state, ST_OPER);
    check("slow", timer_slow_charge, 8'h00);
    // external circuit forces the timer pin high
    timer_force = 1'b1;
    wait_st(ST_RESTART);
    timer_force = 1'b0;
    wait_st(ST_OPER);
    // pin between thresholds: only the half-bridge stops
    en_above_ic = 1'b0;
    wait_st(ST_HB_OFF);
    cyc(4);
    check("enables", {pfc_enable, hb_enable}, 8'h02);
    check("hold", hb_low_side_hold, 8'h01);
    en_above_ic = 1'b1;
    wait_st(ST_OPER);
    // overvoltage latches; mains dip and recovery clears
    output_sense_ovp = 1'b1;
    wait_st(ST_PROT_SD);
    output_sense_ovp = 1'b0;
    cyc(30);
    check("state", state, ST_PROT_SD);
    check("outs", outs(), 8'h00);
    mains_below_rst = 1'b1;
    mains_above_hys = 1'b0;
    cyc(5);
    check("state", state, ST_PROT_SD);
    mains_below_rst = 1'b0;
    mains_above_hys = 1'b1;
    wait_st(ST_STARTUP);
    wait_st(ST_OPER);
    // supplies below reset clear the latch
    output_sense_ovp = 1'b1;
    wait_st(ST_PROT_SD);
    output_sense_ovp = 1'b0;
    supplies_rst = 1'b1;
    cyc(5);
    supplies_rst = 1'b0;
    check("left", state != ST_PROT_SD, 8'h01);
    wait_st(ST_OPER);
    // pin pulled low from operation, then from the latch
    en_above_pfc = 1'b0;
    en_above_ic = 1'b0;
    cyc(3);
    check("pfc", pfc_enable, 8'h00);
    wait_st(ST_DISABLED);
    cyc(4);
    check("hb", hb_enable, 8'h00);
    check("hold", hb_low_side_hold, 8'h01);
    en_above_pfc = 1'b1;
    en_above_ic = 1'b1;
    wait_st(ST_OPER);
    output_sense_ovp = 1'b1;
    wait_st(ST_PROT_SD);
    en_above_pfc = 1'b0;
    en_above_ic = 1'b0;
    wait_st(ST_DISABLED);
    en_above_pfc = 1'b1;
    en_above_ic = 1'b1;
    output_sense_ovp = 1'b0;
    wait_st(ST_OPER);
    // over-temperature beside an overvoltage: thermal hold wins
    otp_active = 1'b1;
    output_sense_ovp = 1'b1;
    wait_st(ST_THERMAL);
    cyc(10);
    check("state", state, ST_THERMAL);
    check("outs", outs(), 8'h00);
    output_sense_ovp = 1'b0;
    otp_active = 1'b0;
    wait_st(ST_STARTUP);
    finish_test();
  end
endmodule
